// *** common/epb_pkg.sv ***
// Purpose: constants and carriers for the engineering packet param block
// Assumes: one 250 MHz clock, APB register access
// Notes:   packet bit numbers are absolute positions in the packet
package epb_pkg;
  // -----------------------------------------------------------------
  // status block layout
  // -----------------------------------------------------------------
  localparam int BLK_WORDS    = 20;
  localparam int WORD_BITS    = 16;
  localparam int BLK_BITS     = 320;
  localparam int BLK_START    = 2192;
  localparam int BLK_END      = 2511;
  localparam int FILL_START   = 2503;
  localparam int FILL_LEN     = 9;
  localparam int BIT_SCI_QLK  = 2335;
  localparam int BIT_ENG_QLK  = 2367;
  localparam int BIT_ALIVE    = 2319;
  localparam int BIT_PD_HTR   = 2481;
  localparam int BIT_SPH_FB   = 2482;
  localparam int BIT_LOV_SHDN = 2483;
  localparam int BIT_LAMP_LVL = 2484;
  localparam int POS_LAMP_CFG = 2485;
  localparam int POS_PROC_LOG = 2488;
  localparam int POS_FMT_LOG  = 2492;
  localparam int BIT_IR_SRC   = 2496;
  localparam int POS_ONE_W    = 2498;
  localparam int BIT_VIS_ECAL = 2500;
  localparam int BIT_NIR_ECAL = 2501;
  localparam int BIT_SCI_NORM = 2502;
  // -----------------------------------------------------------------
  // gain table area
  // -----------------------------------------------------------------
  localparam int GAIN_WORDS = 550;
  localparam int GAIN_BITS  = 4400;
  localparam int GAIN_START = 144;
  // -----------------------------------------------------------------
  // register map (byte addresses) and reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_STATUS  = 8'h04;
  localparam logic [7:0] ADR_FIELDS  = 8'h08;
  localparam logic [7:0] ADR_SHARED  = 8'h0c;
  localparam logic [7:0] ADR_BLKIDX  = 8'h10;
  localparam logic [7:0] ADR_BLKDAT  = 8'h14;
  localparam logic [7:0] ADR_GAINADR = 8'h18;
  localparam logic [7:0] ADR_GAINDAT = 8'h1c;
  localparam logic [2:0] SHARED_RST  = 3'h0;
  localparam logic       PKTSEL_RST  = 1'b0;
  localparam logic       COLLECT_RST = 1'b1;

  typedef enum logic [1:0] {
    EPB_IDLE = 2'b00,
    EPB_SEND = 2'b01,
    EPB_DONE = 2'b11
  } epb_state_t;

  // one status word from the control processor
  typedef struct packed {
    logic        valid;
    logic        first;
    logic [15:0] data;
  } epb_cpword_t;

  // decoded calibrator and logging fields of the block tail
  typedef struct packed {
    logic       refPdHeater;
    logic       sphereFbSel;
    logic       lampOvShdnN;
    logic       lampLevel;
    logic [2:0] lampCfg;
    logic [3:0] procLogClass;
    logic [3:0] fmtLogClass;
    logic       irSource;
    logic [1:0] oneWattLamp;
    logic       visElecCal;
    logic       nirElecCal;
    logic       sciNormal;
  } epb_fields_t;

  // serial packet bit stream
  typedef struct packed {
    logic        valid;
    logic        data;
    logic        last;
    logic [12:0] num;
  } epb_ser_t;
endpackage

// *** src/epb_param_block.sv ***
// Purpose: collects the per-scan status block and streams the packet
//          bits of the status block or of the gain table area
// Assumes: control processor logic runs on ref_clk; APB master
// Notes:   pready rises one cycle after setup; every access takes two
//
// Notes on behaviour
// - status block arrives once per scan as twenty sixteen-bit words
// - in each word the most significant bit is position zero
// - set and reset commands share one bit per flag pair
// - short pulse commands and spares are never placed in the block
// - nine fill bits start at packet bit 2503; block ends at 2511
// - status block is exactly 320 packet bits
// - bit 2481 is the reference photodiode heater, one means on
// - bit 2482 selects sphere feedback, one means radiance
// - bit 2483 is lamp overvoltage shutdown, zero means enabled
// - bit 2484 is lamp level, one means high
// - three-bit lamp configuration field starts at bit 2485
// - four-bit log classes at bit 2488 and at bit 2492
// - bit 2496 is the infrared source, one means on
// - two-bit one-watt lamp field at bit 2498, lamp five first
// - bits 2500 and 2501 are visible and near-ir electronic cal
// - bit 2502 is the science flag, zero means abnormal
// - gain area holds 550 eight-bit words, 4400 bits
// - gain word zero starts at packet bit 144, words ascending
// - status block begins at packet bit 2192
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module epb_param_block (
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire logic                 clkEn,
  input  wire epb_pkg::epb_cpword_t cpWord,
  input  wire logic [2:0]           cmdSet,
  input  wire logic [2:0]           cmdReset,
  input  wire logic                 pulseCmd,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  output epb_pkg::epb_fields_t      fieldsOut,
  output epb_pkg::epb_ser_t         serOut
);
  localparam int BS = epb_pkg::BLK_START;

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [0:319]          colBlk_q, colBlk_d;
  logic [0:319]          pubBlk_q, pubBlk_d;
  logic [0:319]          txBlk_q, txBlk_d;
  logic [4:0]            wordCnt_q, wordCnt_d;
  logic [15:0]           scanCnt_q, scanCnt_d;
  logic                  blkValid_q, blkValid_d;
  logic                  overrun_q, overrun_d;
  logic [2:0]            shared_q, shared_d;
  logic                  pktSel_q, pktSel_d;
  logic                  collect_q, collect_d;
  logic [4:0]            blkIdx_q, blkIdx_d;
  logic [9:0]            gainAdr_q, gainAdr_d;
  logic [31:0]           prdata_q, prdata_d;
  logic                  pready_q, pready_d;
  logic                  pslverr_q, pslverr_d;
  epb_pkg::epb_fields_t  fields_q, fields_d;
  epb_pkg::epb_state_t   state_q, state_d;
  logic [12:0]           txIdx_q, txIdx_d;
  logic                  txGain_q, txGain_d;
  epb_pkg::epb_ser_t     ser_q, ser_d;
  logic [7:0]            gainMem [0:epb_pkg::GAIN_WORDS-1];

  logic                  wrAcc;
  logic                  setupCyc;
  logic                  startReq;
  logic                  gainWe;
  logic [7:0]            gainRd;
  logic [7:0]            gainTxByte;
  logic [0:319]          shaped;

  assign setupCyc   = psel & ~penable;
  // write commits only on the edge that the master sees pready high
  assign wrAcc      = psel & penable & pready_q & pwrite;
  assign startReq   = wrAcc & (paddr == epb_pkg::ADR_CTRL) & pwdata[0];
  assign gainWe     = wrAcc & (paddr == epb_pkg::ADR_GAINDAT) &
                      (gainAdr_q < 10'(epb_pkg::GAIN_WORDS));
  assign gainRd     = gainMem[gainAdr_q];
  assign gainTxByte = gainMem[txIdx_q[12:3]];

  // -----------------------------------------------------------------
  // block shaping: shared bits and zero fill
  // -----------------------------------------------------------------
  // shared set/reset bits replace the word content; they sit once each
  always_comb begin
    shaped = colBlk_q;
    shaped[epb_pkg::BIT_SCI_QLK - BS] = shared_q[0];
    shaped[epb_pkg::BIT_ENG_QLK - BS] = shared_q[1];
    shaped[epb_pkg::BIT_ALIVE - BS]   = shared_q[2];
    shaped[epb_pkg::FILL_START - BS +: epb_pkg::FILL_LEN] = '0;
  end

  // -----------------------------------------------------------------
  // word collection from the control processor
  // -----------------------------------------------------------------
  // a first-word marker restarts the count, so a torn scan self-heals
  always_comb begin
    colBlk_d   = colBlk_q;
    pubBlk_d   = pubBlk_q;
    wordCnt_d  = wordCnt_q;
    scanCnt_d  = scanCnt_q;
    blkValid_d = blkValid_q;
    overrun_d  = overrun_q;
    shared_d   = shared_q;
    fields_d   = fields_q;
    // set beats reset when both arrive together
    for (int i = 0; i < 3; i++) begin
      if (cmdSet[i]) begin
        shared_d[i] = 1'b1;
      end else if (cmdReset[i]) begin
        shared_d[i] = 1'b0;
      end
    end
    // pulse commands act elsewhere and never enter the block
    if (pulseCmd) begin
      colBlk_d = colBlk_q;
    end
    if (cpWord.valid && collect_q) begin
      if (cpWord.first) begin
        colBlk_d[0 +: 16] = cpWord.data;
        wordCnt_d = 5'h01;
      end else if (wordCnt_q < 5'(epb_pkg::BLK_WORDS)) begin
        colBlk_d[16*wordCnt_q +: 16] = cpWord.data;
        wordCnt_d = wordCnt_q + 5'h01;
      end else begin
        overrun_d = 1'b1;
      end
    end
    // the twentieth word completes the scan's 320-bit block
    if (wordCnt_q == 5'(epb_pkg::BLK_WORDS) &&
        !(cpWord.valid && collect_q)) begin
      pubBlk_d   = shaped;
      blkValid_d = 1'b1;
      scanCnt_d  = scanCnt_q + 16'h0001;
      wordCnt_d  = 5'h00;
    end
    // write-one clears; a new overrun in the same cycle still holds
    if (wrAcc && paddr == epb_pkg::ADR_STATUS && pwdata[2] &&
        !(cpWord.valid && collect_q && !cpWord.first &&
          wordCnt_q >= 5'(epb_pkg::BLK_WORDS))) begin
      overrun_d = 1'b0;
    end
    // decoded view of the published tail fields
    fields_d.refPdHeater  = pubBlk_q[epb_pkg::BIT_PD_HTR - BS];
    fields_d.sphereFbSel  = pubBlk_q[epb_pkg::BIT_SPH_FB - BS];
    fields_d.lampOvShdnN  = pubBlk_q[epb_pkg::BIT_LOV_SHDN - BS];
    fields_d.lampLevel    = pubBlk_q[epb_pkg::BIT_LAMP_LVL - BS];
    fields_d.lampCfg      = pubBlk_q[epb_pkg::POS_LAMP_CFG - BS +: 3];
    fields_d.procLogClass = pubBlk_q[epb_pkg::POS_PROC_LOG - BS +: 4];
    fields_d.fmtLogClass  = pubBlk_q[epb_pkg::POS_FMT_LOG - BS +: 4];
    fields_d.irSource     = pubBlk_q[epb_pkg::BIT_IR_SRC - BS];
    fields_d.oneWattLamp  = pubBlk_q[epb_pkg::POS_ONE_W - BS +: 2];
    fields_d.visElecCal   = pubBlk_q[epb_pkg::BIT_VIS_ECAL - BS];
    fields_d.nirElecCal   = pubBlk_q[epb_pkg::BIT_NIR_ECAL - BS];
    fields_d.sciNormal    = pubBlk_q[epb_pkg::BIT_SCI_NORM - BS];
  end

  // collection registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      colBlk_q   <= '0;
      pubBlk_q   <= '0;
      wordCnt_q  <= 5'h00;
      scanCnt_q  <= 16'h0000;
      blkValid_q <= 1'b0;
      overrun_q  <= 1'b0;
      shared_q   <= epb_pkg::SHARED_RST;
      fields_q   <= '0;
    end else if (clkEn) begin
      colBlk_q   <= colBlk_d;
      pubBlk_q   <= pubBlk_d;
      wordCnt_q  <= wordCnt_d;
      scanCnt_q  <= scanCnt_d;
      blkValid_q <= blkValid_d;
      overrun_q  <= overrun_d;
      shared_q   <= shared_d;
      fields_q   <= fields_d;
    end
  end

  // -----------------------------------------------------------------
  // APB slave
  // -----------------------------------------------------------------
  // read data is captured in the setup cycle so prdata is a flop
  always_comb begin
    prdata_d   = prdata_q;
    pready_d   = 1'b0;
    pslverr_d  = 1'b0;
    pktSel_d   = pktSel_q;
    collect_d  = collect_q;
    blkIdx_d   = blkIdx_q;
    gainAdr_d  = gainAdr_q;
    if (setupCyc) begin
      pready_d = 1'b1;
      prdata_d = 32'h0000_0000;
      case (paddr)
        epb_pkg::ADR_CTRL: begin
          prdata_d[2:1] = {collect_q, pktSel_q};
        end
        epb_pkg::ADR_STATUS: begin
          prdata_d[0]     = (state_q != epb_pkg::EPB_IDLE);
          prdata_d[1]     = blkValid_q;
          prdata_d[2]     = overrun_q;
          prdata_d[9:5]   = wordCnt_q;
          prdata_d[31:16] = scanCnt_q;
        end
        epb_pkg::ADR_FIELDS: begin
          prdata_d[20:0] = fields_q;
        end
        epb_pkg::ADR_SHARED: begin
          prdata_d[2:0] = shared_q;
        end
        epb_pkg::ADR_BLKIDX: begin
          prdata_d[4:0] = blkIdx_q;
        end
        epb_pkg::ADR_BLKDAT: begin
          if (blkIdx_q < 5'(epb_pkg::BLK_WORDS)) begin
            prdata_d[15:0] = pubBlk_q[16*blkIdx_q +: 16];
          end
        end
        epb_pkg::ADR_GAINADR: begin
          prdata_d[9:0] = gainAdr_q;
        end
        epb_pkg::ADR_GAINDAT: begin
          prdata_d[7:0] = gainRd;
        end
        default: begin
          pslverr_d = 1'b1;
        end
      endcase
    end else if (psel && penable && !pready_q) begin
      pready_d  = 1'b1;
    end else if (psel && penable && pready_q) begin
      pslverr_d = 1'b0;
    end
    // error flag stands with pready through the access cycle
    if (!setupCyc && pready_q && psel && penable) begin
      pready_d  = 1'b0;
    end
    if (pready_q && psel && penable) begin
      pslverr_d = 1'b0;
    end else if (!setupCyc) begin
      pslverr_d = pslverr_q;
    end
    if (wrAcc) begin
      case (paddr)
        epb_pkg::ADR_CTRL: begin
          pktSel_d  = pwdata[1];
          collect_d = pwdata[2];
        end
        epb_pkg::ADR_BLKIDX: begin
          blkIdx_d = pwdata[4:0];
        end
        epb_pkg::ADR_GAINADR: begin
          gainAdr_d = pwdata[9:0];
        end
        epb_pkg::ADR_GAINDAT: begin
          if (gainWe) begin
            gainAdr_d = gainAdr_q + 10'h001;
          end
        end
        default: begin
          pktSel_d = pktSel_q;
        end
      endcase
    end
  end

  // bus-side registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      pktSel_q  <= epb_pkg::PKTSEL_RST;
      collect_q <= epb_pkg::COLLECT_RST;
      blkIdx_q  <= 5'h00;
      gainAdr_q <= 10'h000;
    end else if (clkEn) begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      pktSel_q  <= pktSel_d;
      collect_q <= collect_d;
      blkIdx_q  <= blkIdx_d;
      gainAdr_q <= gainAdr_d;
    end
  end

  // gain table store: 550 bytes, no reset needed for data
  always_ff @(posedge ref_clk) begin
    if (clkEn && gainWe) begin
      gainMem[gainAdr_q] <= pwdata[7:0];
    end
  end

  // -----------------------------------------------------------------
  // packet bit serializer
  // -----------------------------------------------------------------
  // block is snapshotted at start so a new scan cannot tear the stream
  always_comb begin
    state_d  = state_q;
    txIdx_d  = txIdx_q;
    txGain_d = txGain_q;
    txBlk_d  = txBlk_q;
    ser_d    = ser_q;
    ser_d.valid = 1'b0;
    ser_d.last  = 1'b0;
    case (state_q)
      epb_pkg::EPB_IDLE: begin
        if (startReq) begin
          state_d  = epb_pkg::EPB_SEND;
          txIdx_d  = 13'h0000;
          txGain_d = pktSel_q;
          txBlk_d  = pubBlk_q;
        end
      end
      epb_pkg::EPB_SEND: begin
        ser_d.valid = 1'b1;
        if (txGain_q) begin
          // byte-wide words, msb first, ascending offsets
          ser_d.data = gainTxByte[3'h7 - txIdx_q[2:0]];
          ser_d.num  = 13'(epb_pkg::GAIN_START) + txIdx_q;
          ser_d.last = (txIdx_q == 13'(epb_pkg::GAIN_BITS - 1));
        end else begin
          ser_d.data = txBlk_q[txIdx_q[8:0]];
          ser_d.num  = 13'(BS) + txIdx_q;
          ser_d.last = (txIdx_q == 13'(epb_pkg::BLK_BITS - 1));
        end
        txIdx_d = txIdx_q + 13'h0001;
        if (ser_d.last) begin
          state_d = epb_pkg::EPB_DONE;
        end
      end
      epb_pkg::EPB_DONE: begin
        state_d = epb_pkg::EPB_IDLE;
      end
      default: begin
        state_d = epb_pkg::EPB_IDLE;
      end
    endcase
  end

  // serializer registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= epb_pkg::EPB_IDLE;
      txIdx_q  <= 13'h0000;
      txGain_q <= 1'b0;
      txBlk_q  <= '0;
      ser_q    <= '0;
    end else if (clkEn) begin
      state_q  <= state_d;
      txIdx_q  <= txIdx_d;
      txGain_q <= txGain_d;
      txBlk_q  <= txBlk_d;
      ser_q    <= ser_d;
    end
  end

  // outputs straight from flops
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign fieldsOut = fields_q;
  assign serOut    = ser_q;
endmodule

// *** tb/epb_cp_model.sv ***
// Purpose: control processor stand-in, one status block per go pulse
// Assumes: words go out whole, one per valid pulse, word 0 first
// Notes:   data line toggles outside words, never holds the last word
`timescale 1ns/100ps
module epb_cp_model (
  input  wire logic            ref_clk,
  input  wire logic            resetn,
  input  wire logic            go,
  input  wire logic [3:0]      gap,
  input  wire logic [0:319]    blkIn,
  output epb_pkg::epb_cpword_t cpWord,
  output logic                 busy
);
  int w;
  int g;
  // one word per slot, gap idle cycles between words for a slow sender
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cpWord <= '0;
      busy   <= 1'b0;
      w      <= 0;
      g      <= 0;
    end else begin
      cpWord <= {2'b00, ~cpWord.data}; // stale value would hide bugs
      if (go && !busy) begin
        busy <= 1'b1;
        w    <= 0;
        g    <= 0;
      end else if (busy && g != 0) begin
        g <= g - 1;
      end else if (busy && w == 20) begin
        busy <= 1'b0;
      end else if (busy) begin
        cpWord <= {1'b1, w == 0, blkIn[16*w +: 16]};
        w      <= w + 1;
        g      <= int'(gap);
      end
    end
  end
endmodule

// *** tb/epb_param_block_properties.sv ***
// Purpose: port-level properties of the param block
// Assumes: clkEn held high by the bench
// Notes:   the first bit number of a stream tells status from gain
`timescale 1ns/100ps
module epb_param_block_properties (
  input wire logic              ref_clk,
  input wire logic              resetn,
  input wire logic              clkEn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [31:0]       prdata,
  input wire epb_pkg::epb_ser_t serOut
);
  logic [12:0] bitCnt_q;
  logic [12:0] bitCnt_d;
  logic        blk_q;
  logic        blk_d;
  logic        lastBit;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // stream bookkeeping
  // ----------------------------------------------------------------
  // bits since stream start; first bit number names the stream
  always_comb begin
    bitCnt_d = serOut.valid ? bitCnt_q + 13'h1 : 13'h0;
    blk_d    = (serOut.valid && bitCnt_q == 13'h0) ?
               (serOut.num == 13'h890) : blk_q;
  end
  assign lastBit = serOut.valid && serOut.last;
  // registers only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bitCnt_q <= 13'h0;
      blk_q    <= 1'b0;
    end else begin
      bitCnt_q <= bitCnt_d;
      blk_q    <= blk_d;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence sSetup;
    psel && !penable && clkEn;
  endsequence
  sequence sAnswer;
    pready && penable ##1 !pready;
  endsequence
  AST_APB_ANSWER: assert property (sSetup |=> sAnswer)
    else $error("pready not in the single access cycle");
  AST_SLVERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer without ready or with data");
  AST_START_POS: assert property ($rose(serOut.valid) |->
    serOut.num == 13'h890 || serOut.num == 13'h90)
    else $error("stream started at wrong bit");
  AST_NUM_STEP: assert property (serOut.valid && !serOut.last |=>
    serOut.valid && serOut.num == $past(serOut.num) + 13'h1)
    else $error("bit number did not step by one");
  AST_LAST_POS: assert property (lastBit |->
    (serOut.num == 13'h9cf || serOut.num == 13'h11bf) ##1 !serOut.valid)
    else $error("stream ended at wrong bit");
  AST_BLK_LEN: assert property (lastBit && blk_q |->
    bitCnt_q == 13'h13f) else $error("status block length wrong");
  AST_GAIN_LEN: assert property (lastBit && !blk_q |->
    bitCnt_q == 13'h112f) else $error("gain area length wrong");
  AST_FILL_ZERO: assert property (serOut.valid && blk_q &&
    serOut.num >= 13'h9c7 |-> !serOut.data) else $error("fill bit set");
endmodule
bind epb_param_block epb_param_block_properties
  epb_param_block_properties_inst (.ref_clk(ref_clk), .resetn(resetn),
  .clkEn(clkEn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .serOut(serOut));

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the param block
// Assumes: clkEn held high; the APB master idles one cycle per access
// Notes:   expected packets are built here from the bit layout
`timescale 1ns/100ps
module testbench;
  logic                 ref_clk, resetn, clkEn, pulseCmd, go, busy;
  logic                 psel, penable, pwrite, pready, pslverr, err;
  logic [2:0]           cmdSet, cmdReset;
  logic [3:0]           gap;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [0:319]         blkIn;
  logic [0:4399]        capBits;
  epb_pkg::epb_cpword_t cpWord;
  epb_pkg::epb_fields_t fieldsOut;
  epb_pkg::epb_ser_t    serOut;
  int                   num_errors, num_checks, cyc;
  epb_param_block epb_param_block_inst (.ref_clk(ref_clk),
    .resetn(resetn), .clkEn(clkEn), .cpWord(cpWord), .cmdSet(cmdSet),
    .cmdReset(cmdReset), .pulseCmd(pulseCmd), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fieldsOut(fieldsOut), .serOut(serOut));
  epb_cp_model epb_cp_model_inst (.ref_clk(ref_clk), .resetn(resetn),
    .go(go), .gap(gap), .blkIn(blkIn), .cpWord(cpWord), .busy(busy));
  // clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one APB transfer; the trailing idle cycle keeps drives apart
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  // collect one stream by packet bit number
  task automatic capture(input int base);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (serOut.valid === 1'b1) capBits[int'(serOut.num) - base] = serOut.data;
    end while (serOut.last !== 1'b1 && n < 6000);
    chk({31'h0, n < 6000}, 32'h1);
  endtask
  function automatic logic [7:0] gb(input int i);
    return 8'(i * 37 + 5);
  endfunction
  task automatic t_reset();
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask
  // a scan with shared-bit commands and a pulse command, then stream it
  task automatic t_scan(input logic [0:319] v, input logic [3:0] g,
    input logic [2:0] s, input logic [2:0] r, input logic [2:0] sh,
    input logic [15:0] k);
    logic [0:319] e;
    int n;
    cmdSet <= s;
    cmdReset <= r;
    pulseCmd <= 1'b1;
    blkIn <= v;
    gap <= g;
    go <= 1'b1;
    @(posedge ref_clk);
    cmdSet <= 3'h0;
    cmdReset <= 3'h0;
    pulseCmd <= 1'b0;
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (busy !== 1'b0 && n < 600);
    repeat (3) @(posedge ref_clk);
    e = v;
    e[127] = sh[2];
    e[143] = sh[0];
    e[175] = sh[1];
    e[311:319] = '0;
    chk({11'h0, fieldsOut}, {11'h0, e[289:304], e[306:310]});
    // published, no overrun, count back at zero, scan counted
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, {k, 16'h0002});
    apb(1'b1, 8'h10, 32'h0000_0013);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, {16'h0, e[304:319]});
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, {29'h0, sh});
    apb(1'b1, 8'h00, 32'h5);
    capture(2192);
    for (int w = 0; w < 20; w++)
      chk({16'h0, capBits[16*w +: 16]}, {16'h0, e[16*w +: 16]});
  endtask
  task automatic t_gain();
    apb(1'b1, 8'h18, 32'h0);
    for (int i = 0; i < 550; i++)
      apb(1'b1, 8'h1c, {24'h0, gb(i)});
    // a store past the last word is refused and leaves the pointer
    apb(1'b1, 8'h1c, 32'h0000_00ff);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0000_0226);
    apb(1'b1, 8'h18, 32'h5);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd, {24'h0, gb(5)});
    apb(1'b1, 8'h00, 32'h6);
    apb(1'b1, 8'h00, 32'h7);
    capture(144);
    for (int i = 0; i < 550; i++)
      chk({24'h0, capBits[8*i +: 8]}, {24'h0, gb(i)});
  endtask
  // main sequence
  initial begin
    resetn = 1'b0;
    clkEn = 1'b1;
    pulseCmd = 1'b0;
    go = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    cmdSet = 3'h0;
    cmdReset = 3'h0;
    gap = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    blkIn = '0;
    num_errors = 0;
    num_checks = 0;
    cyc = 0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    // word content differs from the shared bits at bit 143 in the first scan, at bits 127 and 175 in the second
    t_scan({10{32'h1234abcd}}, 4'h0, 3'h5, 3'h0, 3'h5, 16'h0001);
    t_scan({10{32'h0ff0a55a}}, 4'h3, 3'h2, 3'h3, 3'h6, 16'h0002);
    t_gain();
    close_out();
  end
endmodule
